// [pkg/csbu_pkg.sv]
// Shared types and constants of the compare, skip and branch unit.
package csbu_pkg;

  // Datapath widths.
  localparam int CSBU_DATA_W = 8;
  localparam int CSBU_PC_W = 16;
  localparam int CSBU_OFF_W = 7;

  // Status register bit positions.
  localparam int CSBU_FLAG_C = 0;
  localparam int CSBU_FLAG_Z = 1;
  localparam int CSBU_FLAG_N = 2;
  localparam int CSBU_FLAG_V = 3;
  localparam int CSBU_FLAG_H = 5;

  // Program counter steps in words.
  localparam logic [CSBU_PC_W-1:0] CSBU_STEP_NEXT = 16'h0001;
  localparam logic [CSBU_PC_W-1:0] CSBU_STEP_SKIP_SHORT = 16'h0002;
  localparam logic [CSBU_PC_W-1:0] CSBU_STEP_SKIP_LONG = 16'h0003;

  // Cycle counts of each outcome.
  localparam logic [1:0] CSBU_CYC_ONE = 2'h1;
  localparam logic [1:0] CSBU_CYC_TWO = 2'h2;
  localparam logic [1:0] CSBU_CYC_THREE = 2'h3;

  // Reset values.
  localparam logic [CSBU_PC_W-1:0] CSBU_PC_RESET = 16'h0000;
  localparam logic [CSBU_DATA_W-1:0] CSBU_STATUS_REGISTER_RESET = 8'h00;

  typedef enum logic [3:0] {
    compare_skip_equal,
    compare_regs,
    compare_with_borrow_in,
    compare_immediate,
    skip_reg_bit_clear,
    skip_reg_bit_set,
    skip_io_bit_clear,
    skip_io_bit_set,
    branch_flag_set,
    branch_flag_clear,
    branch_equal,
    branch_unequal,
    branch_borrow_set,
    branch_borrow_clear
  } csbu_op_type;

  typedef struct packed {
    csbu_op_type op;
    logic [CSBU_DATA_W-1:0] dst_val;
    logic [CSBU_DATA_W-1:0] src_reg;
    logic [CSBU_DATA_W-1:0] imm;
    logic [CSBU_DATA_W-1:0] io_val;
    logic [2:0] bit_sel;
    logic [2:0] flag_sel;
    logic [CSBU_OFF_W-1:0] offset;
    logic [CSBU_DATA_W-1:0] status_register;
    logic [CSBU_PC_W-1:0] program_counter;
    logic next_two_word;
  } csbu_req_type;

  typedef struct packed {
    logic [CSBU_PC_W-1:0] program_counter;
    logic [CSBU_DATA_W-1:0] status_register;
    logic status_we;
  } csbu_res_type;

  function automatic logic [CSBU_PC_W-1:0] csbu_pc_plus(
    input logic [CSBU_PC_W-1:0] pc,
    input logic [CSBU_PC_W-1:0] delta
  );
    return pc + delta;
  endfunction : csbu_pc_plus

  function automatic logic [CSBU_PC_W-1:0] csbu_sext_off(
    input logic [CSBU_OFF_W-1:0] off
  );
    return {{(CSBU_PC_W-CSBU_OFF_W){off[CSBU_OFF_W-1]}}, off};
  endfunction : csbu_sext_off

endpackage : csbu_pkg

// [src/csbu_sub_flags.sv]
// Subtract-and-flag logic for the compare instructions.
`timescale 1ns/1ps
`default_nettype none
module csbu_sub_flags
  import csbu_pkg::*;
(
  // Operands.
  input wire logic [CSBU_DATA_W-1:0] a,
  input wire logic [CSBU_DATA_W-1:0] b,
  input wire logic borrow_in,
  input wire logic chain_zero,
  // Flags in and out.
  input wire logic [CSBU_DATA_W-1:0] status_register_in,
  output logic [CSBU_DATA_W-1:0] status_register_out
);

  logic [CSBU_DATA_W:0] diff;
  logic [CSBU_DATA_W-1:0] r;

  always_comb begin
    diff = {1'b0, a} - {1'b0, b} - {{CSBU_DATA_W{1'b0}}, borrow_in};
    r = diff[CSBU_DATA_W-1:0];
    status_register_out = status_register_in;
    status_register_out[CSBU_FLAG_C] = diff[CSBU_DATA_W];
    // With chaining the zero flag only survives if it was already set.
    status_register_out[CSBU_FLAG_Z] = (r == 8'h00) &
                            (~chain_zero | status_register_in[CSBU_FLAG_Z]);
    status_register_out[CSBU_FLAG_N] = r[7];
    status_register_out[CSBU_FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    status_register_out[CSBU_FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
  end

endmodule : csbu_sub_flags
`default_nettype wire

// [src/csbu_unit.sv]
// Compare, skip and conditional branch unit of the core.
// Functional notes
// - Equal registers skip next; no flags changed.
// - Compares set Z N V C H, one cycle.
// - Register bit zero skips next instruction.
// - Register bit one skips next instruction.
// - I/O bit zero skips next instruction.
// - I/O bit one skips next instruction.
// - Selected flag set branches pc+k+1.
// - Selected flag clear branches pc+k+1.
// - Zero flag set branches pc+k+1.
// - Zero flag clear branches pc+k+1.
// - Carry set branches pc+k+1.
// - Carry clear branches pc+k+1.
`timescale 1ns/1ps
`default_nettype none
module csbu_unit
  import csbu_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Instruction request.
  input wire logic req_valid,
  input wire csbu_req_type req,
  output logic req_ready,
  // Result.
  output logic done,
  output csbu_res_type res
);

  typedef enum logic {
    ST_IDLE,
    ST_HOLD
  } csbu_state_type;

  csbu_state_type state;
  logic [1:0] remain;
  logic take;
  logic [CSBU_DATA_W-1:0] cmp_status_register;
  logic [CSBU_DATA_W-1:0] cmp_b;
  logic skip_cond;
  logic br_cond;
  logic is_cmp;
  logic is_skip;
  logic [CSBU_PC_W-1:0] next_pc;
  logic [1:0] next_cyc;

  assign take = req_valid & req_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Condition decode.

  always_comb begin
    cmp_b = (req.op == compare_immediate) ? req.imm : req.src_reg;
    skip_cond = 1'b0;
    br_cond = 1'b0;
    is_cmp = 1'b0;
    is_skip = 1'b0;
    unique case (req.op)
      compare_skip_equal: begin
        is_skip = 1'b1;
        skip_cond = (req.dst_val == req.src_reg);
      end
      compare_regs, compare_with_borrow_in, compare_immediate: begin
        is_cmp = 1'b1;
      end
      skip_reg_bit_clear: begin
        is_skip = 1'b1;
        skip_cond = ~req.src_reg[req.bit_sel];
      end
      skip_reg_bit_set: begin
        is_skip = 1'b1;
        skip_cond = req.src_reg[req.bit_sel];
      end
      skip_io_bit_clear: begin
        is_skip = 1'b1;
        skip_cond = ~req.io_val[req.bit_sel];
      end
      skip_io_bit_set: begin
        is_skip = 1'b1;
        skip_cond = req.io_val[req.bit_sel];
      end
      branch_flag_set: begin
        br_cond = req.status_register[req.flag_sel];
      end
      branch_flag_clear: begin
        br_cond = ~req.status_register[req.flag_sel];
      end
      branch_equal: begin
        br_cond = req.status_register[CSBU_FLAG_Z];
      end
      branch_unequal: begin
        br_cond = ~req.status_register[CSBU_FLAG_Z];
      end
      branch_borrow_set: begin
        br_cond = req.status_register[CSBU_FLAG_C];
      end
      branch_borrow_clear: begin
        br_cond = ~req.status_register[CSBU_FLAG_C];
      end
      // Unused operation codes complete as a plain one-word step.
      default: begin
      end
    endcase
  end

  csbu_sub_flags u_sub (
    .a(req.dst_val),
    .b(cmp_b),
    .borrow_in((req.op == compare_with_borrow_in) &
               req.status_register[CSBU_FLAG_C]),
    .chain_zero(req.op == compare_with_borrow_in),
    .status_register_in(req.status_register),
    .status_register_out(cmp_status_register)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next program counter and cycle count.

  always_comb begin
    next_pc = csbu_pc_plus(req.program_counter, CSBU_STEP_NEXT);
    next_cyc = CSBU_CYC_ONE;
    if (is_skip && skip_cond) begin
      if (req.next_two_word) begin
        next_pc = csbu_pc_plus(req.program_counter,
                               CSBU_STEP_SKIP_LONG);
        next_cyc = CSBU_CYC_THREE;
      end else begin
        next_pc = csbu_pc_plus(req.program_counter,
                               CSBU_STEP_SKIP_SHORT);
        next_cyc = CSBU_CYC_TWO;
      end
    end else if (br_cond) begin
      next_pc = csbu_pc_plus(next_pc, csbu_sext_off(req.offset));
      next_cyc = CSBU_CYC_TWO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result capture.

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      res <= '{CSBU_PC_RESET, CSBU_STATUS_REGISTER_RESET, 1'b0};
    end else if (take) begin
      res.program_counter <= next_pc;
      res.status_register <= is_cmp ? cmp_status_register :
                             req.status_register;
      res.status_we <= is_cmp;
    end else if (done) begin
      res.status_we <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer.

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      remain <= 2'h0;
      done <= 1'b0;
      req_ready <= 1'b1;
    end else begin
      unique case (state)
        ST_IDLE: begin
          done <= 1'b0;
          if (take) begin
            if (next_cyc == CSBU_CYC_ONE) begin
              done <= 1'b1;
            end else begin
              state <= ST_HOLD;
              remain <= next_cyc - 2'h1;
              req_ready <= 1'b0;
            end
          end
        end
        ST_HOLD: begin
          remain <= remain - 2'h1;
          if (remain == 2'h1) begin
            state <= ST_IDLE;
            done <= 1'b1;
            req_ready <= 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_cmp_one_cycle;
    @(posedge ref_clk) disable iff (!rst_n)
    take && is_cmp |=> done && res.status_we;
  endproperty
  a_cmp_one_cycle: assert property (p_cmp_one_cycle)
    else $error("compare did not finish in one cycle");

  property p_cmp_carry;
    @(posedge ref_clk) disable iff (!rst_n)
    take && req.op == compare_regs |=>
      res.status_register[CSBU_FLAG_C] ==
        ($past(req.dst_val) < $past(req.src_reg));
  endproperty
  a_cmp_carry: assert property (p_cmp_carry)
    else $error("compare carry flag wrong");

  // The result pc and flags only move at an accept, so the first edge after a skip is
  // accepted shows what it leaves for its whole duration.
  property p_skip_no_flags;
    @(posedge ref_clk) disable iff (!rst_n)
    take && is_skip |=> !res.status_we &&
      res.status_register == $past(req.status_register);
  endproperty
  a_skip_no_flags: assert property (p_skip_no_flags)
    else $error("skip wrote the status register");

  property p_equal_skip_short;
    @(posedge ref_clk) disable iff (!rst_n)
    take && req.op == compare_skip_equal && req.dst_val == req.src_reg &&
      !req.next_two_word |=> !done ##1 done &&
      res.program_counter == csbu_pc_plus($past(req.program_counter, 2),
                                          CSBU_STEP_SKIP_SHORT);
  endproperty
  a_equal_skip_short: assert property (p_equal_skip_short)
    else $error("equal skip short wrong");

  property p_equal_no_skip;
    @(posedge ref_clk) disable iff (!rst_n)
    take && req.op == compare_skip_equal && req.dst_val != req.src_reg |=>
      done && res.program_counter ==
        csbu_pc_plus($past(req.program_counter), CSBU_STEP_NEXT);
  endproperty
  a_equal_no_skip: assert property (p_equal_no_skip)
    else $error("unequal compare skipped");

  property p_regbit_skip_long;
    @(posedge ref_clk) disable iff (!rst_n)
    take && req.op == skip_reg_bit_clear && !req.src_reg[req.bit_sel] &&
      req.next_two_word |=> !done [*2] ##1 done &&
      res.program_counter == csbu_pc_plus($past(req.program_counter, 3),
                                          CSBU_STEP_SKIP_LONG);
  endproperty
  a_regbit_skip_long: assert property (p_regbit_skip_long)
    else $error("long skip wrong");

  property p_iobit_set_skip;
    @(posedge ref_clk) disable iff (!rst_n)
    take && req.op == skip_io_bit_set && req.io_val[req.bit_sel] |->
      ##[2:3] done;
  endproperty
  a_iobit_set_skip: assert property (p_iobit_set_skip)
    else $error("io bit set skip missing");

  property p_flag_branch_taken;
    @(posedge ref_clk) disable iff (!rst_n)
    take && req.op == branch_flag_set &&
      req.status_register[req.flag_sel] |=> !done ##1 done &&
      res.program_counter == csbu_pc_plus(
        csbu_pc_plus($past(req.program_counter, 2),
                     csbu_sext_off($past(req.offset, 2))), CSBU_STEP_NEXT);
  endproperty
  a_flag_branch_taken: assert property (p_flag_branch_taken)
    else $error("taken flag branch wrong");

  property p_unequal_not_taken;
    @(posedge ref_clk) disable iff (!rst_n)
    take && req.op == branch_unequal && req.status_register[CSBU_FLAG_Z] |=>
      done && !res.status_we && res.program_counter ==
        csbu_pc_plus($past(req.program_counter), CSBU_STEP_NEXT);
  endproperty
  a_unequal_not_taken: assert property (p_unequal_not_taken)
    else $error("branch on unequal taken wrongly");

  property p_ready_low_while_held;
    @(posedge ref_clk) disable iff (!rst_n)
    take && req.op == branch_borrow_set &&
      req.status_register[CSBU_FLAG_C] |=> !req_ready ##1 req_ready && done;
  endproperty
  a_ready_low_while_held: assert property (p_ready_low_while_held)
    else $error("carry branch timing wrong");

endmodule : csbu_unit
`default_nettype wire

// [verification/csbu_unit_tb_top.sv]
// Self-checking bench of the compare, skip and branch unit.
`timescale 1ns/1ps
`default_nettype none
module csbu_unit_tb_top
  import csbu_pkg::*;
;
  logic ref_clk;
  logic rst_n;
  logic req_valid;
  csbu_req_type req;
  logic req_ready;
  logic done;
  csbu_res_type res;
  int bad_count;
  int checks_done;
  logic [15:0] lfsr;

  csbu_unit DUT (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .req_valid(req_valid),
    .req(req),
    .req_ready(req_ready),
    .done(done),
    .res(res)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic gen(input int i, output csbu_req_type r);
    logic [79:0] v;
    for (int k = 0; k < 5; k++) begin
      lfsr = lfsr_next(lfsr);
      v = {v[63:0], lfsr};
    end
    r = v[73:0];
    r.op = csbu_op_type'(4'(i % 14));
    // Equal operands make the equality skip and the zero chain reachable.
    if (i % 3 == 0) begin
      r.src_reg = r.dst_val;
    end
  endtask : gen

  ////////////////////////////////////////////////////////////////////////////
  // Reference model: expected next pc, flags, flag write and cycle count.
  task automatic model(input csbu_req_type r, output logic [15:0] pc,
      output logic [7:0] sr, output logic we, output int n);
    logic [7:0] d;
    logic [7:0] s;
    logic [7:0] q;
    logic hit;
    logic skip;
    logic cin;
    d = r.dst_val;
    s = (r.op == compare_immediate) ? r.imm : r.src_reg;
    cin = (r.op == compare_with_borrow_in) ? r.status_register[0] : 1'b0;
    q = d - s - {7'h00, cin};
    sr = r.status_register;
    we = 1'b0;
    n = 1;
    hit = 1'b0;
    skip = 1'b0;
    pc = r.program_counter + 16'h0001;
    case (r.op)
      compare_regs, compare_with_borrow_in, compare_immediate: begin
        we = 1'b1;
        sr[0] = (~d[7] & s[7]) | (s[7] & q[7]) | (q[7] & ~d[7]);
        sr[1] = (q == 8'h00) && (!cin && r.op != compare_with_borrow_in
                                 || r.op == compare_with_borrow_in
                                 && r.status_register[1]);
        sr[2] = q[7];
        sr[3] = (d[7] & ~s[7] & ~q[7]) | (~d[7] & s[7] & q[7]);
        sr[5] = (~d[3] & s[3]) | (s[3] & q[3]) | (q[3] & ~d[3]);
      end
      compare_skip_equal: skip = (d == r.src_reg);
      skip_reg_bit_clear: skip = ~r.src_reg[r.bit_sel];
      skip_reg_bit_set: skip = r.src_reg[r.bit_sel];
      skip_io_bit_clear: skip = ~r.io_val[r.bit_sel];
      skip_io_bit_set: skip = r.io_val[r.bit_sel];
      branch_flag_set: hit = r.status_register[r.flag_sel];
      branch_flag_clear: hit = ~r.status_register[r.flag_sel];
      branch_equal: hit = r.status_register[1];
      branch_unequal: hit = ~r.status_register[1];
      branch_borrow_set: hit = r.status_register[0];
      branch_borrow_clear: hit = ~r.status_register[0];
      default: ;
    endcase
    if (skip) begin
      n = r.next_two_word ? 3 : 2;
      pc = r.program_counter + (r.next_two_word ? 16'h0003 : 16'h0002);
    end
    if (hit) begin
      n = 2;
      pc = r.program_counter + {{9{r.offset[6]}}, r.offset} + 16'h0001;
    end
  endtask : model

  ////////////////////////////////////////////////////////////////////////////
  // Issues one request back to back and checks timing and result at done.
  task automatic run_op(input int i);
    csbu_req_type r;
    csbu_req_type g;
    logic [15:0] epc;
    logic [7:0] esr;
    logic ewe;
    int en;
    int cnt;
    gen(i, r);
    model(r, epc, esr, ewe, en);
    req = r;
    req_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    // Garbage held while busy must be refused.
    if (en > 1) begin
      gen(i + 5, g);
      req = g;
    end
    cnt = 1;
    while (done !== 1'b1 && cnt < 8) begin
      check(req_ready, 1'b0);
      @(posedge ref_clk);
      #1;
      cnt++;
    end
    check(req_ready, 1'b1);
    check(res.program_counter, epc);
    check(res.status_register, esr);
    check(res.status_we, ewe);
    if (r.op >= branch_flag_set) begin
      check(cnt, en);
    end else if (r.op >= skip_reg_bit_clear) begin
      check(cnt, en);
    end else begin
      check(cnt, en);
    end
  endtask : run_op

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    #(100 * 10000);
    bad_count++;
    print_verdict();
  end

  initial begin
    bad_count = 0;
    checks_done = 0;
    lfsr = 16'h0019;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    check(done, 1'b0);
    check(req_ready, 1'b1);
    check(res.program_counter, 16'h0000);
    check(res.status_we, 1'b0);
    for (int i = 0; i < 420; i++) begin
      run_op(i);
    end
    req_valid = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check(done, 1'b0);
    print_verdict();
  end
endmodule : csbu_unit_tb_top
`default_nettype wire
